// ===== rxq_pkg.sv
// receive queue control package: register map, field layout, reset values, timing
// assumes a 200 MHz pclk and one character-time strobe from the uart receiver
package rxq_pkg;
  localparam int ADDR_W = 12;
  localparam int COUNT_W = 10;
  localparam int PTR_W = 9;
  localparam int DEPTH = 512;
  // register indices; the byte address is four times the index
  localparam logic [9:0] IDX_FLUSH = 10'h043;
  localparam logic [9:0] IDX_COUNT = 10'h044;
  localparam logic [9:0] IDX_WIDE = 10'h045;
  localparam logic [9:0] IDX_LOWLAT = 10'h046;
  localparam logic [9:0] IDX_LIMIT = 10'h047;
  localparam logic [9:0] IDX_DRIVER = 10'h060;
  localparam int BIT_FLUSH_NOW = 0;
  localparam int BIT_AUTO_OPEN = 1;
  localparam int BIT_AUTO_CLOSE = 2;
  localparam int BIT_EN = 0;
  localparam logic AUTO_OPEN_RST = 1'b1;
  localparam logic AUTO_CLOSE_RST = 1'b0;
  localparam logic [9:0] LIMIT_RST = 10'h1c2;
  localparam logic [9:0] QUEUE_FULL = 10'h200;
  localparam logic [6:0] PKT_VENDOR = 7'h40;
  localparam logic [6:0] PKT_CLASS = 7'h3f;
  localparam logic [1:0] TIMEOUT_CHARS = 2'h3;
  localparam logic [23:0] LOW_BAUD_BPS = 24'h00a000;
  localparam int CLK_MHZ = 200;

  typedef struct packed {
    logic [2:0] err;
    logic [8:0] data;
  } rx_char_t;

  typedef struct packed {
    logic [15:0] data;
    logic last;
  } in_beat_t;

  typedef enum logic [2:0] {
    F_IDLE = 3'b000,
    F_HOLD = 3'b001,
    F_FETCH = 3'b010,
    F_LOAD = 3'b011,
    F_SHOW = 3'b100,
    F_DONE = 3'b101
  } fwd_state_t;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [9:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction
endpackage

// ===== rxq_mem.sv
// receive queue storage: 512 characters, one write and one registered read port
// assumes the caller never reads and writes the same empty slot in one cycle
`timescale 1ns/1ps
module rxq_mem
  import rxq_pkg::*;
(
  input wire logic pclk,
  input wire logic wr_en,
  input wire logic [PTR_W-1:0] wr_addr,
  input wire rx_char_t wr_data,
  input wire logic rd_en,
  input wire logic [PTR_W-1:0] rd_addr,
  output rx_char_t rd_data
);
  rx_char_t mem [0:DEPTH-1];
  rx_char_t rd_data_r;

  // no reset on the array: it is pure storage and never read before written
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data_r <= mem[rd_addr];
    end
  end

  assign rd_data = rd_data_r;
endmodule

// ===== rxq_ctrl.sv
// receive queue control: apb registers, 512-character queue, bulk-in forwarding, flow threshold
// assumes rx_valid/rx_ready handshake from the uart and one char_tick per character time
`timescale 1ns/1ps
module rxq_ctrl
  import rxq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire rx_char_t rx_char,
  output logic rx_ready,
  input wire logic rx_enable,
  input wire logic char_tick,
  input wire logic [23:0] baud_bps,
  input wire logic flow_ctrl_en,
  output logic flow_stop,
  output logic wide_mode,
  output logic vendor_driver,
  input wire logic bulkin_req,
  output logic in_valid,
  output in_beat_t in_beat,
  input wire logic in_ready,
  output logic in_done
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic auto_open_r, auto_open_nxt, auto_close_r, auto_close_nxt;
  logic wide_r, wide_nxt, lowlat_r, lowlat_nxt, vendor_r, vendor_nxt;
  logic [9:0] limit_r, limit_nxt;
  logic rx_en_q_r, flush;
  logic [COUNT_W-1:0] count_r, count_nxt;
  logic [PTR_W-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
  logic rx_ready_r, rx_ready_nxt, flow_r, flow_nxt;
  fwd_state_t st_r, st_nxt;
  logic [6:0] left_r, left_nxt;
  logic [1:0] tmo_r, tmo_nxt;
  logic in_valid_r, in_valid_nxt, in_done_r, in_done_nxt;
  in_beat_t beat_r, beat_nxt;
  logic push, pop, access, wr_acc, hit;
  logic [6:0] pkt, avail;
  rx_char_t q;

  assign access = psel & penable & pready_r;
  assign wr_acc = access & pwrite;
  assign push = rx_valid & rx_ready_r;
  assign pop = (st_r == F_FETCH);
  assign pkt = vendor_r ? PKT_VENDOR : PKT_CLASS;
  assign avail = (count_r >= {3'h0, pkt}) ? pkt : count_r[6:0];
  // manual flush, or receiver edge with the matching auto bit
  assign flush = (wr_acc && paddr == byte_addr(IDX_FLUSH) && pwdata[BIT_FLUSH_NOW])
    || (auto_open_r && rx_enable && !rx_en_q_r)
    || (auto_close_r && !rx_enable && rx_en_q_r);

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, answer on the second access cycle
  always_comb begin
    pready_nxt = psel & penable & ~pready_r;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0000_0000;
    auto_open_nxt = auto_open_r;
    auto_close_nxt = auto_close_r;
    wide_nxt = wide_r;
    lowlat_nxt = lowlat_r;
    vendor_nxt = vendor_r;
    limit_nxt = limit_r;
    hit = 1'b1;
    if (psel && penable && !pready_r) begin
      case (paddr)
        byte_addr(IDX_FLUSH), byte_addr(IDX_DRIVER): prdata_nxt = 32'h0000_0000;
        byte_addr(IDX_COUNT): prdata_nxt = {22'h0, count_r};
        byte_addr(IDX_WIDE): prdata_nxt = {31'h0, wide_r};
        byte_addr(IDX_LOWLAT): prdata_nxt = {31'h0, lowlat_r};
        byte_addr(IDX_LIMIT): prdata_nxt = {22'h0, limit_r};
        default: hit = 1'b0;
      endcase
      pslverr_nxt = ~hit;
    end
    if (wr_acc) begin
      case (paddr)
        byte_addr(IDX_FLUSH): begin
          auto_open_nxt = pwdata[BIT_AUTO_OPEN];
          auto_close_nxt = pwdata[BIT_AUTO_CLOSE];
        end
        byte_addr(IDX_WIDE): wide_nxt = pwdata[BIT_EN];
        byte_addr(IDX_LOWLAT): lowlat_nxt = pwdata[BIT_EN];
        byte_addr(IDX_LIMIT): limit_nxt = pwdata[9:0];
        byte_addr(IDX_DRIVER): vendor_nxt = pwdata[BIT_EN];
        default: ;
      endcase
    end
    // the hardware set wins over a software clear in the same cycle
    if (!vendor_r && baud_bps < LOW_BAUD_BPS) begin
      lowlat_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      auto_open_r <= AUTO_OPEN_RST;
      auto_close_r <= AUTO_CLOSE_RST;
      wide_r <= 1'b0;
      lowlat_r <= 1'b0;
      vendor_r <= 1'b0;
      limit_r <= LIMIT_RST;
      // starts as enabled: with the reset auto bits a receiver already on gives no false flush
      rx_en_q_r <= 1'b1;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      auto_open_r <= auto_open_nxt;
      auto_close_r <= auto_close_nxt;
      wide_r <= wide_nxt;
      lowlat_r <= lowlat_nxt;
      vendor_r <= vendor_nxt;
      limit_r <= limit_nxt;
      rx_en_q_r <= rx_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // queue pointers and count; a full queue refuses characters through rx_ready
  always_comb begin
    wptr_nxt = wptr_r + (push ? 9'h001 : 9'h000);
    rptr_nxt = rptr_r + (pop ? 9'h001 : 9'h000);
    count_nxt = count_r + {9'h0, push} - {9'h0, pop};
    if (flush) begin
      wptr_nxt = 9'h000;
      rptr_nxt = 9'h000;
      count_nxt = 10'h000;
    end
    rx_ready_nxt = (count_nxt < QUEUE_FULL);
    flow_nxt = flow_ctrl_en && (count_nxt >= limit_r);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_r <= 9'h000;
      rptr_r <= 9'h000;
      count_r <= 10'h000;
      rx_ready_r <= 1'b0;
      flow_r <= 1'b0;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
      count_r <= count_nxt;
      rx_ready_r <= rx_ready_nxt;
      flow_r <= flow_nxt;
    end
  end

  // read data lands one cycle after the pop, so the load state picks it up
  rxq_mem rxq_mem_inst (
    .pclk(pclk),
    .wr_en(push),
    .wr_addr(wptr_r),
    .wr_data(rx_char),
    .rd_en(pop),
    .rd_addr(rptr_r),
    .rd_data(q)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // bulk-in forwarding; a flush aborts any answer in progress
  always_comb begin
    st_nxt = st_r;
    left_nxt = left_r;
    tmo_nxt = tmo_r;
    in_valid_nxt = in_valid_r;
    in_done_nxt = 1'b0;
    beat_nxt = beat_r;
    case (st_r)
      F_IDLE: begin
        tmo_nxt = 2'h0;
        if (bulkin_req) begin
          st_nxt = F_HOLD;
        end
      end
      F_HOLD: begin
        if (char_tick && tmo_r != TIMEOUT_CHARS) begin
          tmo_nxt = tmo_r + 2'h1;
        end
        // immediate forwarding skips the wait entirely
        if (lowlat_r || count_r >= {3'h0, pkt} || tmo_r == TIMEOUT_CHARS) begin
          left_nxt = avail;
          st_nxt = (avail == 7'h00) ? F_DONE : F_FETCH;
        end
      end
      F_FETCH: begin
        left_nxt = left_r - 7'h01;
        st_nxt = F_LOAD;
      end
      F_LOAD: begin
        beat_nxt.data = wide_r ? {4'h0, q.err, q.data} : {8'h00, q.data[7:0]};
        beat_nxt.last = (left_r == 7'h00);
        in_valid_nxt = 1'b1;
        st_nxt = F_SHOW;
      end
      F_SHOW: begin
        if (in_ready) begin
          in_valid_nxt = 1'b0;
          st_nxt = beat_r.last ? F_DONE : F_FETCH;
        end
      end
      F_DONE: begin
        in_done_nxt = 1'b1;
        st_nxt = F_IDLE;
      end
      default: st_nxt = F_IDLE;
    endcase
    if (flush) begin
      st_nxt = F_IDLE;
      in_valid_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= F_IDLE;
      left_r <= 7'h00;
      tmo_r <= 2'h0;
      in_valid_r <= 1'b0;
      in_done_r <= 1'b0;
      beat_r <= '0;
    end else begin
      st_r <= st_nxt;
      left_r <= left_nxt;
      tmo_r <= tmo_nxt;
      in_valid_r <= in_valid_nxt;
      in_done_r <= in_done_nxt;
      beat_r <= beat_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign rx_ready = rx_ready_r;
  assign flow_stop = flow_r;
  assign wide_mode = wide_r;
  assign vendor_driver = vendor_r;
  assign in_valid = in_valid_r;
  assign in_beat = beat_r;
  assign in_done = in_done_r;

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_flush_wr;
    wr_acc && paddr == byte_addr(IDX_FLUSH) && pwdata[BIT_FLUSH_NOW];
  endsequence
  sequence s_rx_on;
    rx_enable && !rx_en_q_r;
  endsequence
  sequence s_rx_off;
    !rx_enable && rx_en_q_r;
  endsequence

  manual_flush_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_flush_wr |=> count_r == 10'h000 && !in_valid_r)
    else $error("manual flush left bytes");
  close_flush_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_rx_off ##0 auto_close_r |=> count_r == 10'h000)
    else $error("disable did not flush");
  open_flush_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_rx_on ##0 auto_open_r |=> count_r == 10'h000)
    else $error("enable did not flush");
  count_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    count_r <= QUEUE_FULL && !(count_r == QUEUE_FULL && rx_ready_r))
    else $error("count beyond capacity");
  hold_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == F_HOLD && !lowlat_r && count_r < {3'h0, pkt} && tmo_r != TIMEOUT_CHARS && !flush
    |=> st_r == F_HOLD)
    else $error("answer left hold early");
  fast_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == F_HOLD && lowlat_r && !flush |=> st_r == F_FETCH || st_r == F_DONE)
    else $error("immediate forward waited");
  class_packet_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == F_HOLD && st_nxt != F_HOLD && !flush |=> left_r <= $past(pkt))
    else $error("packet size too large");
  auto_lowlat_a: assert property (@(posedge pclk) disable iff (!presetn)
    !vendor_r && baud_bps < LOW_BAUD_BPS |=> lowlat_r)
    else $error("low baud did not force forwarding");
  flow_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 flow_r == ($past(flow_ctrl_en) && count_r >= $past(limit_r)))
    else $error("flow stop mismatched threshold");
  limit_reset_a: assert property (@(posedge pclk)
    $rose(presetn) |-> limit_r == LIMIT_RST)
    else $error("fill limit reset wrong");
  fill_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready_r && !pwrite && paddr == byte_addr(IDX_COUNT)
    |=> prdata_r[31:10] == 22'h0 && prdata_r[9:0] == $past(count_r))
    else $error("fill level read wrong");
endmodule

// ===== usb_host_model.sv
// far-side model: usb host issuing bulk-in requests and taking answer beats
// assumes start is a one-cycle pulse from the bench, sent only while the device is idle
`timescale 1ns/1ps
module usb_host_model
  import rxq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic slow,
  output logic bulkin_req,
  output logic in_ready,
  input wire logic in_valid,
  input wire in_beat_t in_beat,
  input wire logic in_done,
  output logic [9:0] beats,
  output in_beat_t last_seen,
  output logic done
);
  ////////////////////////////////////////////////////////////////////////////////
  // slow mode takes a beat only every other cycle, so the device must hold its offer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bulkin_req <= 1'b0;
      in_ready <= 1'b0;
      beats <= 10'h000;
      last_seen <= '0;
      done <= 1'b0;
    end else begin
      bulkin_req <= start;
      in_ready <= slow ? ~in_ready : 1'b1;
      if (start) begin
        beats <= 10'h000;
        done <= 1'b0;
      end
      if (in_valid && in_ready) begin
        beats <= beats + 10'h001;
        last_seen <= in_beat;
      end
      if (in_done) begin
        done <= 1'b1;
      end
    end
  end
endmodule

// ===== uart_rx_fifo_control_bench.sv
// testbench for the receive queue control: apb master, uart source, usb host model
// assumes every bus access and every answer completes; only the watchdog ends a wait
`timescale 1ns/1ps
module uart_rx_fifo_control_bench
  import rxq_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, rx_valid = 1'b0, rx_ready, rx_enable = 1'b1;
  rx_char_t rx_char = '0;
  logic char_tick = 1'b0, flow_ctrl_en = 1'b0, flow_stop, wide_mode, vendor_driver;
  logic [23:0] baud_bps = 24'h01c200;
  logic bulkin_req, in_valid, in_ready, in_done, start = 1'b0, slow = 1'b0, done;
  in_beat_t in_beat, last_seen;
  logic [9:0] beats;
  int failures = 0, checked = 0;

  always #2.5 pclk = ~pclk;

  rxq_ctrl rxq_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_char(rx_char), .rx_ready(rx_ready),
    .rx_enable(rx_enable), .char_tick(char_tick), .baud_bps(baud_bps),
    .flow_ctrl_en(flow_ctrl_en), .flow_stop(flow_stop), .wide_mode(wide_mode),
    .vendor_driver(vendor_driver), .bulkin_req(bulkin_req), .in_valid(in_valid),
    .in_beat(in_beat), .in_ready(in_ready), .in_done(in_done));
  usb_host_model usb_host_model_inst (.pclk(pclk), .presetn(presetn), .start(start),
    .slow(slow), .bulkin_req(bulkin_req), .in_ready(in_ready), .in_valid(in_valid),
    .in_beat(in_beat), .in_done(in_done), .beats(beats), .last_seen(last_seen), .done(done));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge: a following call never drives psel twice in one time step,
    // and register outputs written here are settled when the caller looks
    @(posedge pclk);
  endtask

  task automatic rchk(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  // each char carries error code 2 and data 0x30 upward, so beats are recognisable
  task automatic push(input int n);
    for (int i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_char <= {3'h2, 9'(i + 'h30)};
      @(posedge pclk);
      while (rx_ready !== 1'b1) @(posedge pclk);
    end
    rx_valid <= 1'b0;
    @(posedge pclk);
  endtask

  // waits for the answer already requested; a second request while busy would be ignored
  task automatic wait_done();
    while (done !== 1'b1) begin
      @(posedge pclk);
    end
  endtask

  task automatic ask();
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    repeat (2) @(posedge pclk);
    wait_done();
  endtask

  task automatic flush();
    apb(1'b1, IDX_FLUSH, 32'h3);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rchk(IDX_LIMIT, 32'h1c2);
    rchk(IDX_COUNT, 32'h0);
    rchk(IDX_WIDE, 32'h0);
    rchk(IDX_LOWLAT, 32'h0);
    apb(1'b0, 10'h3ff, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask

  task automatic t_flush();
    push(5);
    rchk(IDX_COUNT, 32'h5);
    flush();
    rchk(IDX_COUNT, 32'h0);
    rchk(IDX_FLUSH, 32'h0);
  endtask

  task automatic t_auto();
    push(3);
    rx_enable <= 1'b0;
    rchk(IDX_COUNT, 32'h3);
    rx_enable <= 1'b1;
    rchk(IDX_COUNT, 32'h0);
    apb(1'b1, IDX_FLUSH, 32'h4);
    push(3);
    rx_enable <= 1'b0;
    rchk(IDX_COUNT, 32'h0);
    push(2);
    rx_enable <= 1'b1;
    rchk(IDX_COUNT, 32'h2);
    flush();
  endtask

  task automatic t_flow();
    apb(1'b1, IDX_LIMIT, 32'h4);
    flow_ctrl_en <= 1'b1;
    push(3);
    chk({31'h0, flow_stop}, 32'h0);
    push(1);
    chk({31'h0, flow_stop}, 32'h1);
    flow_ctrl_en <= 1'b0;
    flush();
    apb(1'b1, IDX_LIMIT, 32'h1c2);
  endtask

  task automatic t_lowlat();
    apb(1'b1, IDX_LOWLAT, 32'h1);
    slow <= 1'b1;
    push(2);
    ask();
    chk({22'h0, beats}, 32'h2);
    chk({15'h0, last_seen}, 32'h00063);
    apb(1'b1, IDX_WIDE, 32'h1);
    chk({31'h0, wide_mode}, 32'h1);
    push(2);
    ask();
    chk({15'h0, last_seen}, 32'h00863);
    apb(1'b1, IDX_WIDE, 32'h0);
    ask();
    chk({22'h0, beats}, 32'h0);
    slow <= 1'b0;
    apb(1'b1, IDX_LOWLAT, 32'h0);
  endtask

  task automatic t_packet();
    apb(1'b1, IDX_DRIVER, 32'h1);
    chk({31'h0, vendor_driver}, 32'h1);
    rchk(IDX_DRIVER, 32'h0);
    push(63);
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    repeat (20) @(posedge pclk);
    chk({22'h0, beats}, 32'h0);
    push(1);
    wait_done();
    chk({22'h0, beats}, 32'h40);
    apb(1'b1, IDX_DRIVER, 32'h0);
    chk({31'h0, vendor_driver}, 32'h0);
    push(63);
    ask();
    chk({22'h0, beats}, 32'h3f);
    push(2);
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      repeat (10) @(posedge pclk);
      chk({31'h0, done}, 32'h0);
      char_tick <= 1'b1;
      @(posedge pclk);
      char_tick <= 1'b0;
    end
    wait_done();
    chk({22'h0, beats}, 32'h2);
  endtask

  task automatic t_baud();
    baud_bps <= 24'h002580;
    rchk(IDX_LOWLAT, 32'h1);
    apb(1'b1, IDX_LOWLAT, 32'h0);
    rchk(IDX_LOWLAT, 32'h1);
    baud_bps <= 24'h01c200;
    apb(1'b1, IDX_LOWLAT, 32'h0);
    rchk(IDX_LOWLAT, 32'h0);
  endtask

  task automatic t_full();
    push(512);
    chk({31'h0, rx_ready}, 32'h0);
    rchk(IDX_COUNT, 32'h200);
    flush();
    rchk(IDX_COUNT, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_flush();
    t_auto();
    t_flow();
    t_lowlat();
    t_packet();
    t_baud();
    t_full();
    results();
  end

  // the whole sequence needs well under 8000 cycles
  initial begin
    repeat (40000) @(posedge pclk);
    failures++;
    results();
  end
endmodule
